//--- hdl/gpx_regs.vh
`ifndef GPX_REGS_VH
`define GPX_REGS_VH

// ------------------------------------------------------------------
// Register indices selected by the low three pointer bits.
// ------------------------------------------------------------------
`define GPX_REG_LEVEL_LO  3'h0
`define GPX_REG_LEVEL_HI  3'h1
`define GPX_REG_DRIVE_LO  3'h2
`define GPX_REG_DRIVE_HI  3'h3
`define GPX_REG_INVERT_LO 3'h4
`define GPX_REG_INVERT_HI 3'h5
`define GPX_REG_DIR_LO    3'h6
`define GPX_REG_DIR_HI    3'h7

// Register group encoded in pointer bits 2 and 1.
`define GPX_GRP_LEVEL     2'h0
`define GPX_GRP_DRIVE     2'h1
`define GPX_GRP_INVERT    2'h2
`define GPX_GRP_DIR       2'h3

// ------------------------------------------------------------------
// Reset values.
// ------------------------------------------------------------------
`define GPX_RST_DRIVE     8'hff
`define GPX_RST_INVERT    8'h00
`define GPX_RST_DIR       8'hff
`define GPX_RST_POINTER   8'h00

// Upper four bits of the seven-bit slave address; the value is arbitrary.
`define GPX_ADDR_UPPER    4'h4

// Cycles after reset during which the change reference tracks the pins.
`define GPX_SETTLE_CYC    2'h3

`endif

//--- hdl/gpx_expander.v
`timescale 1ns/1ps
`default_nettype none
`include "gpx_regs.vh"

// Contract
// - Three strap inputs pick one of eight slave addresses.
// - Address byte last bit: one means read, zero means write.
// - After address acknowledge, the first written byte loads the pointer.
// - Low three pointer bits select the target register; pointer is write only.
// - Pointers 0 and 1 read sampled pin levels regardless of direction.
// - Writes to the level registers are ignored.
// - Level registers have no fixed reset value; they follow the pins.
// - Pointers 2 and 3 drive values; they affect output pins only.
// - Drive register reads return the written value, not the pin.
// - Pointers 4 and 5 are inversion selects acting on the level read of every pin, whatever its direction.
// - Inversion bit one stores the complemented pin level.
// - Inversion bit zero stores the pin level unchanged.
// - Pointers 6 and 7 set direction; one makes a high-impedance input.
// - Direction zero makes the pin a driven output following drive bit.
// - Reset loads defaults and initialises the bus state machine.
// - After each data byte the pointer flips to the pair partner.
// - Change output goes low on any edge of an input pin only.
// - Change clears when pin returns or its port level is read.
module gpx_expander (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        sda_o,
  output reg        sda_oe_o,
  input  wire       addr_strap_bit0_i,
  input  wire       addr_strap_bit1_i,
  input  wire       addr_strap_bit2_i,
  input  wire [7:0] low_port_pin_i,
  input  wire [7:0] high_port_pin_i,
  output reg  [7:0] low_port_pin_o,
  output reg  [7:0] low_port_pin_oe_o,
  output reg  [7:0] high_port_pin_o,
  output reg  [7:0] high_port_pin_oe_o,
  output reg        pin_change_n_o
);

  // ----------------------------------------------------------------
  // Bus state machine encoding.
  // ----------------------------------------------------------------
  localparam [3:0] ST_IDLE  = 4'h0;
  localparam [3:0] ST_ADDR  = 4'h1;
  localparam [3:0] ST_AACK  = 4'h2;
  localparam [3:0] ST_CMD   = 4'h3;
  localparam [3:0] ST_CACK  = 4'h4;
  localparam [3:0] ST_WDATA = 4'h5;
  localparam [3:0] ST_WACK  = 4'h6;
  localparam [3:0] ST_RDATA = 4'h7;
  localparam [3:0] ST_RACK  = 4'h8;

  // ----------------------------------------------------------------
  // Synchronisers for every input from outside the clock domain.
  // ----------------------------------------------------------------
  reg  [1:0] scl_sync_r;
  reg  [1:0] sda_sync_r;
  reg        scl_prev_r;
  reg        sda_prev_r;
  reg  [2:0] strap_meta_r;
  reg  [2:0] strap_r;
  reg  [7:0] lo_meta_r;
  reg  [7:0] lo_pin_r;
  reg  [7:0] hi_meta_r;
  reg  [7:0] hi_pin_r;

  // Two flip-flops per input; only the second stage is read by logic.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_sync_r   <= 2'h3;
      sda_sync_r   <= 2'h3;
      scl_prev_r   <= 1'b1;
      sda_prev_r   <= 1'b1;
      strap_meta_r <= 3'h0;
      strap_r      <= 3'h0;
      lo_meta_r    <= 8'h00;
      lo_pin_r     <= 8'h00;
      hi_meta_r    <= 8'h00;
      hi_pin_r     <= 8'h00;
    end else begin
      scl_sync_r   <= {scl_sync_r[0], scl_i};
      sda_sync_r   <= {sda_sync_r[0], sda_i};
      scl_prev_r   <= scl_sync_r[1];
      sda_prev_r   <= sda_sync_r[1];
      strap_meta_r <= {addr_strap_bit2_i, addr_strap_bit1_i, addr_strap_bit0_i};
      strap_r      <= strap_meta_r;
      lo_meta_r    <= low_port_pin_i;
      lo_pin_r     <= lo_meta_r;
      hi_meta_r    <= high_port_pin_i;
      hi_pin_r     <= hi_meta_r;
    end
  end

  // Bus events seen on the synchronised lines.
  wire scl_s    = scl_sync_r[1];
  wire sda_s    = sda_sync_r[1];
  wire scl_rise = scl_s & ~scl_prev_r;
  wire scl_fall = ~scl_s & scl_prev_r;
  wire bus_start = scl_s & scl_prev_r & sda_prev_r & ~sda_s;
  wire bus_stop  = scl_s & scl_prev_r & ~sda_prev_r & sda_s;

  // ----------------------------------------------------------------
  // Register file and level view.
  // ----------------------------------------------------------------
  reg  [7:0] drive_r  [0:1];
  reg  [7:0] invert_r [0:1];
  reg  [7:0] dir_r    [0:1];
  reg  [7:0] pointer_r;

  // Level registers carry no state of their own: pin level xor inversion.
  wire [7:0] level_lo = lo_pin_r ^ invert_r[0];
  wire [7:0] level_hi = hi_pin_r ^ invert_r[1];

  // Read multiplexer; during the master acknowledge it selects the pair partner.
  reg  [3:0] state_r;
  reg  [7:0] rd_data;
  wire [2:0] rd_sel = (state_r == ST_RACK) ? {pointer_r[2:1], ~pointer_r[0]} : pointer_r[2:0];
  always @* begin
    case (rd_sel)
      `GPX_REG_LEVEL_LO:  rd_data = level_lo;
      `GPX_REG_LEVEL_HI:  rd_data = level_hi;
      `GPX_REG_DRIVE_LO:  rd_data = drive_r[0];
      `GPX_REG_DRIVE_HI:  rd_data = drive_r[1];
      `GPX_REG_INVERT_LO: rd_data = invert_r[0];
      `GPX_REG_INVERT_HI: rd_data = invert_r[1];
      `GPX_REG_DIR_LO:    rd_data = dir_r[0];
      `GPX_REG_DIR_HI:    rd_data = dir_r[1];
      default:            rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Bus slave.
  // ----------------------------------------------------------------
  reg  [3:0] bit_cnt_r;
  reg  [7:0] shift_r;
  reg  [7:0] tx_r;
  reg        rw_r;
  reg        nack_r;
  reg  [1:0] rd_clr;
  wire       ptr_port = pointer_r[0];
  wire       addr_hit = (shift_r[7:1] == {`GPX_ADDR_UPPER, strap_r});

  // Master acknowledge sampled on SCL rise; a level read clears its port flag.
  always @* begin
    rd_clr = 2'h0;
    if (state_r == ST_RACK && scl_rise && pointer_r[2:1] == `GPX_GRP_LEVEL) begin
      rd_clr[ptr_port] = 1'b1;
    end
  end

  // Data byte complete on the eighth SCL fall: store it as this slave starts its acknowledge.
  wire       wr_en    = (state_r == ST_WDATA) && scl_fall && (bit_cnt_r == 4'h8);

  // Serial engine: bits shift in on SCL rise and change out on SCL fall.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r   <= 8'h00;
      tx_r      <= 8'h00;
      rw_r      <= 1'b0;
      nack_r    <= 1'b1;
      sda_o     <= 1'b0;
      sda_oe_o  <= 1'b0;
      pointer_r <= `GPX_RST_POINTER;
    end else begin
      sda_o <= 1'b0;
      if (bus_start) begin
        state_r   <= ST_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe_o  <= 1'b0;
      end else if (bus_stop) begin
        state_r  <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end else if (scl_rise) begin
        case (state_r)
          ST_ADDR, ST_CMD, ST_WDATA: begin
            shift_r   <= {shift_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          ST_RACK: begin
            nack_r <= sda_s;
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state_r)
          ST_ADDR: begin
            if (bit_cnt_r == 4'h8) begin
              if (addr_hit) begin
                rw_r     <= shift_r[0];
                sda_oe_o <= 1'b1;
                state_r  <= ST_AACK;
              end else begin
                state_r <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            bit_cnt_r <= 4'h0;
            tx_r      <= {rd_data[6:0], 1'b0};
            sda_oe_o  <= rw_r & ~rd_data[7];
            state_r   <= rw_r ? ST_RDATA : ST_CMD;
          end
          ST_CMD: begin
            if (bit_cnt_r == 4'h8) begin
              pointer_r <= shift_r;
              sda_oe_o  <= 1'b1;
              state_r   <= ST_CACK;
            end
          end
          ST_CACK: begin
            sda_oe_o  <= 1'b0;
            bit_cnt_r <= 4'h0;
            state_r   <= ST_WDATA;
          end
          ST_WDATA: begin
            if (bit_cnt_r == 4'h8) begin
              sda_oe_o <= 1'b1;
              state_r  <= ST_WACK;
            end
          end
          ST_WACK: begin
            sda_oe_o     <= 1'b0;
            bit_cnt_r    <= 4'h0;
            pointer_r[0] <= ~pointer_r[0];
            state_r      <= ST_WDATA;
          end
          ST_RDATA: begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == 4'h7) begin
              sda_oe_o <= 1'b0;
              state_r  <= ST_RACK;
            end else begin
              sda_oe_o <= ~tx_r[7];
              tx_r     <= {tx_r[6:0], 1'b0};
            end
          end
          ST_RACK: begin
            pointer_r[0] <= ~pointer_r[0];
            bit_cnt_r    <= 4'h0;
            tx_r         <= {rd_data[6:0], 1'b0};
            sda_oe_o     <= ~nack_r & ~rd_data[7];
            state_r      <= nack_r ? ST_IDLE : ST_RDATA;
          end
          default: begin
            sda_oe_o <= 1'b0;
            state_r  <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Register writes; the pair partner for the next byte comes from the pointer flip.
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drive_r[0]  <= `GPX_RST_DRIVE;
      drive_r[1]  <= `GPX_RST_DRIVE;
      invert_r[0] <= `GPX_RST_INVERT;
      invert_r[1] <= `GPX_RST_INVERT;
      dir_r[0]    <= `GPX_RST_DIR;
      dir_r[1]    <= `GPX_RST_DIR;
    end else if (wr_en) begin
      case (pointer_r[2:1])
        `GPX_GRP_DRIVE:  drive_r[ptr_port]  <= shift_r;
        `GPX_GRP_INVERT: invert_r[ptr_port] <= shift_r;
        `GPX_GRP_DIR:    dir_r[ptr_port]    <= shift_r;
        default: begin
        end  // Level registers are read only.
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers.
  // ----------------------------------------------------------------
  // Drive value always presented; enable only where direction bit is zero.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_port_pin_o     <= `GPX_RST_DRIVE;
      high_port_pin_o    <= `GPX_RST_DRIVE;
      low_port_pin_oe_o  <= 8'h00;
      high_port_pin_oe_o <= 8'h00;
    end else begin
      low_port_pin_o     <= drive_r[0];
      high_port_pin_o    <= drive_r[1];
      low_port_pin_oe_o  <= ~dir_r[0];
      high_port_pin_oe_o <= ~dir_r[1];
    end
  end

  // ----------------------------------------------------------------
  // Change detection.
  // ----------------------------------------------------------------
  reg  [7:0] ref_lo_r;
  reg  [7:0] ref_hi_r;
  reg  [1:0] settle_r;
  wire       settling = (settle_r != `GPX_SETTLE_CYC);

  // Difference from the reference on input-direction pins only.
  wire chg_lo = |((lo_pin_r ^ ref_lo_r) & dir_r[0]);
  wire chg_hi = |((hi_pin_r ^ ref_hi_r) & dir_r[1]);

  // Reference tracks the pins after reset, then reloads on a level read.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_lo_r       <= 8'h00;
      ref_hi_r       <= 8'h00;
      settle_r       <= 2'h0;
      pin_change_n_o <= 1'b1;
    end else begin
      if (settling) begin
        settle_r <= settle_r + 2'h1;
      end
      if (settling || rd_clr[0]) begin
        ref_lo_r <= lo_pin_r;
      end
      if (settling || rd_clr[1]) begin
        ref_hi_r <= hi_pin_r;
      end
      // A pin returning to its reference clears the flag; no flag until the reference settles.
      pin_change_n_o <= settling | ~((chg_lo & ~rd_clr[0]) | (chg_hi & ~rd_clr[1]));
    end
  end

endmodule
`default_nettype wire

//--- tb/gpx_expander_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// Pin-level checker for the expander.
// ------------------------------------------
module gpx_expander_sva (
  input wire       clk_i,
  input wire       rst_n_i,
  input wire       scl_i,
  input wire       sda_i,
  input wire       sda_o,
  input wire       sda_oe_o,
  input wire       addr_strap_bit0_i,
  input wire       addr_strap_bit1_i,
  input wire       addr_strap_bit2_i,
  input wire [7:0] low_port_pin_i,
  input wire [7:0] high_port_pin_i,
  input wire [7:0] low_port_pin_o,
  input wire [7:0] low_port_pin_oe_o,
  input wire [7:0] high_port_pin_o,
  input wire [7:0] high_port_pin_oe_o,
  input wire       pin_change_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [7:0] edge_hist_r;
  // Shift in one bit per clock, set when an input-direction pin toggled.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      edge_hist_r <= 8'h00;
    end else begin
      edge_hist_r <= {edge_hist_r[6:0],
        |(((low_port_pin_i ^ $past(low_port_pin_i)) & ~low_port_pin_oe_o) |
          ((high_port_pin_i ^ $past(high_port_pin_i)) & ~high_port_pin_oe_o))};
    end
  end
  property p_rst_vals;
    $rose(rst_n_i) |-> low_port_pin_oe_o == 8'h00 && high_port_pin_oe_o == 8'h00 &&
      low_port_pin_o == 8'hff && high_port_pin_o == 8'hff && pin_change_n_o;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("bad port state after reset");
  property p_port_upd;
    !$stable({low_port_pin_o, low_port_pin_oe_o, high_port_pin_o, high_port_pin_oe_o})
      |-> !scl_i && !$past(scl_i, 2);
  endproperty
  a_port_upd: assert property (p_port_upd) else $error("port changed outside SCL low");
  property p_one_reg;
    $changed(low_port_pin_oe_o) |-> $stable(high_port_pin_oe_o) && $stable(low_port_pin_o)
      && $stable(high_port_pin_o);
  endproperty
  a_one_reg: assert property (p_one_reg) else $error("two registers in one byte");
  property p_chg_cause;
    $fell(pin_change_n_o) |-> |edge_hist_r;
  endproperty
  a_chg_cause: assert property (p_chg_cause) else $error("change with no input edge");
  property p_chg_clear;
    $rose(pin_change_n_o) |-> |edge_hist_r || $past(scl_i, 2) || $past(scl_i, 3) ||
      $past(scl_i, 4) || $past(scl_i, 5);
  endproperty
  a_chg_clear: assert property (p_chg_clear) else $error("change cleared w/o cause");
  property p_oe_scl_low;
    $changed(sda_oe_o) |-> !scl_i;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("SDA moved with SCL high");
  property p_ack_lag;
    $rose(sda_oe_o) |-> $past(scl_i, 2) || $past(scl_i, 3) || $past(scl_i, 4) ||
      $past(scl_i, 5) || $past(scl_i, 6);
  endproperty
  a_ack_lag: assert property (p_ack_lag) else $error("SDA drive late after SCL fall");
  property p_stop_idle;
    scl_i && $rose(sda_i) |=> !sda_oe_o [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("SDA driven after stop");
  c_chg: cover property ($fell(pin_change_n_o));
  c_ack: cover property ($rose(sda_oe_o));
  c_dir: cover property ($changed(low_port_pin_oe_o));
endmodule
`default_nettype wire

//--- tb/gpx_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// Bus master model; SCL stands high between frames.
// ------------------------------------------
module gpx_i2c_master (
  input  wire logic  clk_i,
  input  wire logic  sda_i,
  output logic       scl_o,
  output logic       sda_low_o,
  output logic [7:0] rd_o,
  output logic       rd_tgl_o
);
  // Idle bus: both lines released.
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    rd_o = 8'h00;
    rd_tgl_o = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Start or repeated start: SDA falls while SCL is high.
  task automatic start();
    tk(1);
    sda_low_o = 1'b0;
    tk(5);
    scl_o = 1'b1;
    tk(3);
    sda_low_o = 1'b1;
    tk(3);
    scl_o = 1'b0;
  endtask
  // Stop: SDA rises while SCL is high.
  task automatic stop();
    tk(1);
    sda_low_o = 1'b1;
    tk(5);
    scl_o = 1'b1;
    tk(3);
    sda_low_o = 1'b0;
    tk(6);
  endtask
  // One bit: six clocks low, two high, sampled before the fall.
  task automatic bit_io(input logic b, output logic r);
    tk(1);
    sda_low_o = !b;
    tk(5);
    scl_o = 1'b1;
    tk(2);
    r = sda_i;
    scl_o = 1'b0;
  endtask
  // A byte MSB first, then the acknowledge bit.
  task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q,
                      output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ak, a);
  endtask
  // Reads a byte; a one on ak ends the read.
  task automatic rd_byte(input logic ak);
    logic [7:0] q;
    logic       a;
    xfer(8'hff, ak, q, a);
    rd_o = q;
    rd_tgl_o = !rd_tgl_o;
  endtask
endmodule
`default_nettype wire

//--- tb/gpx_expander_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpx_regs.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
// ------------------------------------------
// Expander bench.
// ------------------------------------------
module gpx_expander_test;
  logic       clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [2:0] st = 3'h0;
  logic [7:0] ext_lo, ext_hi, adw, dl, dh, cl, ch, il, ih, el, eh, exp_b;
  logic [7:0] expq[$];
  int         n_errors = 0, n_compared = 0, seed = 11, cyc = 0;
  wire        scl, sda_low, sda_oe, sda_o, chg_n, tgl;
  wire [7:0]  lo_o, lo_oe, hi_o, hi_oe, rdq;
  // Pins carry the drive where enabled, else the outside level; SDA pulls up.
  wire [7:0]  lo_pin = (lo_oe & lo_o) | (~lo_oe & ext_lo);
  wire [7:0]  hi_pin = (hi_oe & hi_o) | (~hi_oe & ext_hi);
  wire        sda = !(sda_low || (sda_oe && !sda_o));
  always #25 clk_i = ~clk_i;
  gpx_expander uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .addr_strap_bit0_i(st[0]), .addr_strap_bit1_i(st[1]),
    .addr_strap_bit2_i(st[2]), .low_port_pin_i(lo_pin), .high_port_pin_i(hi_pin),
    .low_port_pin_o(lo_o), .low_port_pin_oe_o(lo_oe), .high_port_pin_o(hi_o),
    .high_port_pin_oe_o(hi_oe), .pin_change_n_o(chg_n));
  gpx_i2c_master mst (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low),
    .rd_o(rdq), .rd_tgl_o(tgl));
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Sends address, command and data, each acknowledged.
  task automatic wr(input logic [7:0] b[$]);
    logic [7:0] q;
    logic       a;
    mst.start();
    foreach (b[i]) begin
      mst.xfer(b[i], 1'b1, q, a);
      `CHK("ack", 1'b0, a)
    end
    mst.stop();
  endtask
  // Points at a register and reads two bytes of its pair.
  task automatic rd(input logic [7:0] c, input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] q;
    logic       a;
    mst.start();
    mst.xfer(adw, 1'b1, q, a);
    mst.xfer(c, 1'b1, q, a);
    mst.start();
    mst.xfer(adw | 8'h01, 1'b1, q, a);
    `CHK("read ack", 1'b0, a)
    expq.push_back(e0);
    expq.push_back(e1);
    mst.rd_byte(1'b0);
    mst.rd_byte(1'b1);
    mst.stop();
  endtask
  task automatic wait_chg(input logic e);
    for (int k = 0; k < 12 && chg_n !== e; k++) begin
      tk(1);
    end
    `CHK("change", e, chg_n)
  endtask
  function automatic logic [7:0] lvl(input logic [7:0] c, d, e, i);
    return ((~c & d) | (c & e)) ^ i;
  endfunction
  // Compares each returned byte with the oldest note.
  always @(tgl) begin
    if (rst_n_i) begin
      exp_b = expq.pop_front();
      `CHK("read data", exp_b, rdq)
    end
  end
  // Cuts a hung run short.
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    logic [7:0] q;
    logic       a;
    {ext_lo, ext_hi} = 16'($random(seed));
    adw = {`GPX_ADDR_UPPER, st, 1'b0};
    tk(2);
    rst_n_i = 1'b1;
    tk(8);
    `CHK("enables", 16'h0000, {hi_oe, lo_oe})
    `CHK("drives", 16'hffff, {hi_o, lo_o})
    rd(8'h02, 8'hff, 8'hff);
    rd(8'h04, 8'h00, 8'h00);
    rd(8'h07, 8'hff, 8'hff);
    $display("reset test done");
    ext_hi[0] = !ext_hi[0];
    wait_chg(1'b0);
    ext_hi[0] = !ext_hi[0];
    wait_chg(1'b1);
    ext_hi[3] = !ext_hi[3];
    wait_chg(1'b0);
    rd(8'h01, ext_hi, ext_lo);
    wait_chg(1'b1);
    $display("change test done");
    for (int s = 0; s < 8; s++) begin
      st = 3'(s);
      tk(4);
      mst.start();
      mst.xfer({`GPX_ADDR_UPPER, st ^ 3'h1, 1'b0}, 1'b1, q, a);
      `CHK("nack", 1'b1, a)
      mst.stop();
      adw = {`GPX_ADDR_UPPER, st, 1'b0};
      wr('{adw, 8'h02, 8'(s)});
      `CHK("strap drive", 8'(s), lo_o)
    end
    $display("address test done");
    {dl, dh, cl, ch} = 32'($random(seed));
    wr('{adw, 8'hfa, dl, dh});
    wr('{adw, 8'h07, ch, cl});
    `CHK("port lo", {~cl, dl}, {lo_oe, lo_o})
    `CHK("port hi", {~ch, dh}, {hi_oe, hi_o})
    rd(8'h03, dh, dl);
    rd(8'h06, cl, ch);
    $display("drive test done");
    {ext_lo, ext_hi, il, ih} = 32'($random(seed));
    wr('{adw, 8'h04, il, ih});
    el = lvl(cl, dl, ext_lo, il);
    eh = lvl(ch, dh, ext_hi, ih);
    rd(8'h00, el, eh);
    wr('{adw, 8'h00, ~el, ~eh});
    rd(8'h00, el, eh);
    wr('{adw, 8'h02, ~dl, ~dh});
    tk(4);
    `CHK("out pin change", 1'b1, chg_n)
    $display("level test done");
    tk(20);
    final_report();
  end
endmodule
bind gpx_expander gpx_expander_sva chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .addr_strap_bit0_i(addr_strap_bit0_i),
  .addr_strap_bit1_i(addr_strap_bit1_i), .addr_strap_bit2_i(addr_strap_bit2_i),
  .low_port_pin_i(low_port_pin_i), .high_port_pin_i(high_port_pin_i),
  .low_port_pin_o(low_port_pin_o), .low_port_pin_oe_o(low_port_pin_oe_o),
  .high_port_pin_o(high_port_pin_o), .high_port_pin_oe_o(high_port_pin_oe_o),
  .pin_change_n_o(pin_change_n_o));
`default_nettype wire
